/* File: hdl/cic_defs.vh */
// Constants for the cascaded interrupt controller pair
`ifndef CIC_DEFS_VH
`define CIC_DEFS_VH
// Register indices, byte address is index times four
`define CIC_IDX_MST_EVEN 8'h20
`define CIC_IDX_MST_ODD 8'h21
`define CIC_IDX_SLV_EVEN 8'ha0
`define CIC_IDX_SLV_ODD 8'ha1
// Command word bit positions
`define CIC_INIT_BIT 4
`define CIC_OCW3_BIT 3
`define CIC_LTM_BIT 3
`define CIC_SNGL_BIT 1
`define CIC_IC4_BIT 0
`define CIC_AUTO_SERVICE_DONE_BIT 1
`define CIC_RR_BIT 1
`define CIC_RIS_BIT 0
`define CIC_ESMM_BIT 6
`define CIC_SMM_BIT 5
`define CIC_ROT_BIT 7
`define CIC_SL_BIT 6
`define CIC_EOI_BIT 5
// Reset and init values
`define CIC_LOWEST_RST 3'h7
`define CIC_CAS_RST 8'h07
`define CIC_SPUR_CHAN 3'h7
`define CIC_ONE_HOT 8'h01
// Bus responses
`define CIC_RESP_OK 2'h0
`define CIC_RESP_ERR 2'h2
`endif

/* File: hdl/cic_prio.v */
// Rotating priority resolver for eight channels
`timescale 1ns/100ps
`include "cic_defs.vh"
module cic_prio (
  input wire [7:0] bits,
  input wire [2:0] lowest,
  output reg found,
  output reg [2:0] chan,
  output reg [2:0] rank
);
  reg [3:0] k;
  reg [2:0] c;
  // Scan from highest priority, which follows the lowest one
  always @* begin
    found = 1'b0;
    chan = `CIC_SPUR_CHAN;
    rank = 3'h7;
    c = 3'h0;
    for (k = 4'h0; k < 4'h8; k = k + 4'h1) begin
      c = lowest + k[2:0] + 3'h1;
      if (bits[c] && !found) begin
        found = 1'b1;
        chan = c;
        rank = k[2:0];
      end
    end
  end
endmodule // cic_prio

/* File: hdl/cic_top.v */
// Master and slave interrupt controllers with AXI4-Lite register access
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "cic_defs.vh"
module cic_top #(
  parameter ADDR_W = 12
) (
  input wire sys_clk,
  input wire rst,
  input wire timerOut0,
  input wire rtcIrq,
  input wire extRequestPin1,
  input wire [7:3] masterPins,
  input wire [7:1] slavePins,
  input wire ackCycle,
  output wire cpuIrqLine,
  output reg [7:0] systemDataBus,
  output reg vectorValid,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam PH_FIRST = 1'b0;
  localparam PH_SECOND = 1'b1;
  localparam ST_IDLE = 2'h0;
  localparam ST_VECTOR_INIT_WORD = 2'h1;
  localparam ST_ICW3 = 2'h2;
  localparam ST_ICW4 = 2'h3;

  reg awHeld, wHeld, wLane, ackPhase, viaSlave;
  reg [7:0] awIdx, wByte;
  wire [7:0] arIdx;
  wire [1:0] hpFound, irqF, singleF, ackFirstC, ackSecondC, wrCtlHit;
  wire [5:0] hpChanF, ackChanF;
  wire [9:0] vecBaseF;
  wire [15:0] casWordF, rdEvenF, rdOddF, reqIn;
  wire doWrite, wrOdd, ackFirst, ackSecond, mstCasc, casHit;
  wire [2:0] mstChan;

  // fixed sources; pins; slave request into master channel 2
  assign reqIn = {slavePins, rtcIrq, masterPins, irqF[1], extRequestPin1, timerOut0};
  assign cpuIrqLine = irqF[0];

  // AXI write side: address and data taken in either order
  assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
  assign s_axi_wready = ~wHeld & ~s_axi_bvalid;
  assign doWrite = awHeld & wHeld & ~s_axi_bvalid;
  assign wrCtlHit[0] = (awIdx == `CIC_IDX_MST_EVEN) | (awIdx == `CIC_IDX_MST_ODD);
  assign wrCtlHit[1] = (awIdx == `CIC_IDX_SLV_EVEN) | (awIdx == `CIC_IDX_SLV_ODD);
  assign wrOdd = awIdx[0];

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awIdx <= 8'h00;
      wByte <= 8'h00;
      wLane <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CIC_RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awIdx <= s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wByte <= s_axi_wdata[7:0];
        wLane <= s_axi_wstrb[0];
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (|wrCtlHit) ? `CIC_RESP_OK : `CIC_RESP_ERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI read side
  assign s_axi_arready = ~s_axi_rvalid;
  assign arIdx = s_axi_araddr[9:2];
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CIC_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `CIC_RESP_OK;
      case (arIdx)
        `CIC_IDX_MST_EVEN: s_axi_rdata <= {24'h000000, rdEvenF[7:0]};
        `CIC_IDX_MST_ODD: s_axi_rdata <= {24'h000000, rdOddF[7:0]};
        `CIC_IDX_SLV_EVEN: s_axi_rdata <= {24'h000000, rdEvenF[15:8]};
        `CIC_IDX_SLV_ODD: s_axi_rdata <= {24'h000000, rdOddF[15:8]};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `CIC_RESP_ERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // acknowledge cycles counted as first and second
  assign ackFirst = ackCycle & (ackPhase == PH_FIRST);
  assign ackSecond = ackCycle & (ackPhase == PH_SECOND);
  assign mstChan = hpChanF[2:0];
  assign mstCasc = hpFound[0] & casWordF[mstChan] & ~singleF[0];
  assign casHit = mstCasc & (casWordF[10:8] == mstChan);
  assign ackFirstC = {ackFirst & casHit, ackFirst};
  assign ackSecondC = {ackSecond & viaSlave, ackSecond};

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ackPhase <= PH_FIRST;
      viaSlave <= 1'b0;
      systemDataBus <= 8'h00;
      vectorValid <= 1'b0;
    end else begin
      vectorValid <= 1'b0;
      if (ackFirst) begin
        ackPhase <= PH_SECOND;
        viaSlave <= casHit;
      end
      if (ackSecond) begin
        ackPhase <= PH_FIRST;
        vectorValid <= 1'b1;
        // base field; channel in low bits
        if (viaSlave) begin
          systemDataBus <= {vecBaseF[9:5], ackChanF[5:3]};
        end else begin
          systemDataBus <= {vecBaseF[4:0], ackChanF[2:0]};
        end
      end
    end
  end

  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : ctl
      reg [7:0] request_latch, in_service_latch, channel_mask, reqPrev, casWord;
      reg [4:0] vecBase;
      reg [2:0] lowest, ackChan;
      reg [1:0] initStep;
      reg level, single, needIc4, auto_service_done, autoRot, smm, readIsr, ackReal, irq;
      wire [7:0] req, pend, svcEff, edgeSet, ackSet, eoiClr, aeoiClr, next_irr, next_isr;
      wire [2:0] pChan, pRank, sChan, sRank, eoiChan;
      wire pFound, sFound, wrHere, first_init_word, rotation_eoi_word, ocw3, oddWr, eoiCmd, eoiDo, rotOnEoi, aeoiDo, want;

      assign req = reqIn[c*8 +: 8];
      assign pend = request_latch & ~channel_mask;
      // masked in-service bits hidden in special mask mode
      assign svcEff = in_service_latch & ~(smm ? channel_mask : 8'h00);

      cic_prio pendRes (
        .bits(pend),
        .lowest(lowest),
        .found(pFound),
        .chan(pChan),
        .rank(pRank)
      );
      cic_prio svcRes (
        .bits(svcEff),
        .lowest(lowest),
        .found(sFound),
        .chan(sChan),
        .rank(sRank)
      );

      assign wrHere = doWrite & wLane & wrCtlHit[c];
      assign first_init_word = wrHere & ~wrOdd & wByte[`CIC_INIT_BIT];
      assign rotation_eoi_word = wrHere & ~wrOdd & ~wByte[`CIC_INIT_BIT] & ~wByte[`CIC_OCW3_BIT];
      assign ocw3 = wrHere & ~wrOdd & ~wByte[`CIC_INIT_BIT] & wByte[`CIC_OCW3_BIT];
      assign oddWr = wrHere & wrOdd;

      assign eoiCmd = rotation_eoi_word & wByte[`CIC_EOI_BIT];
      assign eoiChan = wByte[`CIC_SL_BIT] ? wByte[2:0] : sChan;
      assign eoiDo = eoiCmd & (wByte[`CIC_SL_BIT] | sFound);
      assign rotOnEoi = wByte[`CIC_ROT_BIT] | autoRot;
      assign aeoiDo = ackSecondC[c] & auto_service_done & ackReal;

      // level or rising edge detection; set request
      assign edgeSet = level ? req : (req & ~reqPrev);
      // first acknowledge moves the winner into service
      assign ackSet = (ackFirstC[c] & pFound) ? (`CIC_ONE_HOT << pChan) : 8'h00;
      assign eoiClr = eoiDo ? (`CIC_ONE_HOT << eoiChan) : 8'h00;
      assign aeoiClr = aeoiDo ? (`CIC_ONE_HOT << ackChan) : 8'h00;
      assign next_irr = ((request_latch & ~ackSet) & (level ? req : 8'hff)) | edgeSet;
      // several bits may be in service
      assign next_isr = (in_service_latch & ~eoiClr & ~aeoiClr) | ackSet;
      // outranks in service; equal and lower blocked
      assign want = pFound & (~sFound | (pRank < sRank));

      always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          request_latch <= 8'h00;
          in_service_latch <= 8'h00;
          channel_mask <= 8'h00;
          reqPrev <= 8'h00;
          vecBase <= 5'h00;
          casWord <= `CIC_CAS_RST;
          lowest <= `CIC_LOWEST_RST;
          ackChan <= `CIC_SPUR_CHAN;
          initStep <= ST_IDLE;
          level <= 1'b0;
          single <= 1'b0;
          needIc4 <= 1'b0;
          auto_service_done <= 1'b0;
          autoRot <= 1'b0;
          smm <= 1'b0;
          readIsr <= 1'b0;
          ackReal <= 1'b0;
          irq <= 1'b0;
        end else begin
          reqPrev <= req;
          request_latch <= next_irr;
          in_service_latch <= next_isr;
          if (ackFirstC[c]) begin
            irq <= 1'b0;
          end else begin
            irq <= want;
          end
          if (ackFirstC[c]) begin
            ackChan <= pFound ? pChan : `CIC_SPUR_CHAN;
            ackReal <= pFound;
          end
          if (aeoiDo && autoRot) begin
            lowest <= ackChan;
          end
          if (first_init_word) begin
            channel_mask <= 8'h00;
            lowest <= `CIC_LOWEST_RST;
            casWord <= `CIC_CAS_RST;
            smm <= 1'b0;
            readIsr <= 1'b0;
            autoRot <= 1'b0;
            level <= wByte[`CIC_LTM_BIT];
            single <= wByte[`CIC_SNGL_BIT];
            needIc4 <= wByte[`CIC_IC4_BIT];
            initStep <= ST_VECTOR_INIT_WORD;
          end else if (rotation_eoi_word) begin
            if (eoiDo && rotOnEoi) begin
              lowest <= eoiChan;
            end
            if (wByte[`CIC_ROT_BIT] && wByte[`CIC_SL_BIT] && !wByte[`CIC_EOI_BIT]) begin
              lowest <= wByte[2:0];
            end
            if (!wByte[`CIC_SL_BIT] && !wByte[`CIC_EOI_BIT]) begin
              autoRot <= wByte[`CIC_ROT_BIT];
            end
          end else if (ocw3) begin
            if (wByte[`CIC_RR_BIT]) begin
              readIsr <= wByte[`CIC_RIS_BIT];
            end
            if (wByte[`CIC_ESMM_BIT]) begin
              smm <= wByte[`CIC_SMM_BIT];
            end
          end else if (oddWr) begin
            case (initStep)
              ST_IDLE: channel_mask <= wByte;
              ST_VECTOR_INIT_WORD: begin
                vecBase <= wByte[7:3];
                if (!single) begin
                  initStep <= ST_ICW3;
                end else if (needIc4) begin
                  initStep <= ST_ICW4;
                end else begin
                  initStep <= ST_IDLE;
                end
              end
              ST_ICW3: begin
                casWord <= wByte;
                initStep <= needIc4 ? ST_ICW4 : ST_IDLE;
              end
              ST_ICW4: begin
                auto_service_done <= wByte[`CIC_AUTO_SERVICE_DONE_BIT];
                initStep <= ST_IDLE;
              end
              default: initStep <= ST_IDLE;
            endcase
          end
        end
      end

      assign hpFound[c] = pFound;
      assign hpChanF[c*3 +: 3] = pChan;
      assign irqF[c] = irq;
      assign ackChanF[c*3 +: 3] = ackChan;
      assign vecBaseF[c*5 +: 5] = vecBase;
      assign casWordF[c*8 +: 8] = casWord;
      assign singleF[c] = single;
      assign rdEvenF[c*8 +: 8] = readIsr ? in_service_latch : request_latch;
      assign rdOddF[c*8 +: 8] = channel_mask;
    end
  endgenerate
endmodule // cic_top

/* File: tb/cic_monitor.sv */
// Port checker for the interrupt controller pair
`timescale 1ns/100ps
module cic_monitor (
  input wire sys_clk,
  input wire rst,
  input wire ackCycle,
  input wire cpuIrqLine,
  input wire [7:0] systemDataBus,
  input wire vectorValid,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  reg ackPhase;
  reg secondSeen;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ackPhase <= 1'b0;
      secondSeen <= 1'b0;
    end else begin
      secondSeen <= ackCycle && ackPhase;
      if (ackCycle) begin
        ackPhase <= !ackPhase;
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  vec_timing_a: assert property (vectorValid == secondSeen)
    else $error("vector pulse not one cycle after second acknowledge");
  vec_hold_a: assert property (!vectorValid |-> $stable(systemDataBus))
    else $error("vector changed outside second acknowledge");
  irq_drop_a: assert property (ackCycle && !ackPhase |=> !cpuIrqLine)
    else $error("request line still high after first acknowledge");
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response not released");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during response");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  cover property (vectorValid && systemDataBus[2:0] == 3'h7);
  cover property (ackCycle && !ackPhase ##1 !cpuIrqLine);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule // cic_monitor
bind cic_top cic_monitor mon (.sys_clk(sys_clk), .rst(rst), .ackCycle(ackCycle), .cpuIrqLine(cpuIrqLine),
  .systemDataBus(systemDataBus), .vectorValid(vectorValid), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

/* File: tb/cic_host_model.sv */
// Host processor model answering requests with acknowledge pairs
`timescale 1ns/100ps
module cic_host_model (
  input wire sys_clk,
  input wire rst,
  input wire cpuIrqLine,
  input wire autoAck,
  input wire forceAck,
  input wire [3:0] gap,
  output reg ackCycle
);
  initial ackCycle = 1'b0;
  always begin
    @(posedge sys_clk);
    if (!rst && ((cpuIrqLine && autoAck) || forceAck)) begin
      ackCycle <= 1'b1;
      @(posedge sys_clk);
      if (gap != 4'h0) begin
        ackCycle <= 1'b0;
        repeat (gap) @(posedge sys_clk);
        ackCycle <= 1'b1;
      end
      @(posedge sys_clk);
      ackCycle <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
  end
endmodule // cic_host_model

/* File: tb/tb_cascaded_interrupt_controller.sv */
// Testbench for the cascaded interrupt controller pair
`timescale 1ns/100ps
module tb_cascaded_interrupt_controller;
  reg sys_clk = 1'b0;
  reg rst = 1'b1;
  reg timerOut0 = 1'b0, rtcIrq = 1'b0, extRequestPin1 = 1'b0;
  reg [7:3] masterPins = 5'h00;
  reg [7:1] slavePins = 7'h00;
  reg [11:0] awaddr = 12'h000, araddr = 12'h000;
  reg [31:0] wdata = 32'h0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
  reg autoAck = 1'b1, forceAck = 1'b0;
  reg [3:0] gap = 4'h0;
  wire ackCycle, cpuIrqLine, vectorValid, awready, wready, bvalid, arready, rvalid;
  wire [7:0] systemDataBus;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer failures = 0, check_count = 0, i;
  logic [19:0] initTab [8] = '{20'h08011, 20'h08408, 20'h08404, 20'h08401,
    20'h28011, 20'h28470, 20'h28402, 20'h28401};
  always #20 sys_clk = ~sys_clk;
  cic_top dut (.sys_clk(sys_clk), .rst(rst), .timerOut0(timerOut0), .rtcIrq(rtcIrq),
    .extRequestPin1(extRequestPin1), .masterPins(masterPins), .slavePins(slavePins), .ackCycle(ackCycle),
    .cpuIrqLine(cpuIrqLine), .systemDataBus(systemDataBus), .vectorValid(vectorValid),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  cic_host_model host (.sys_clk(sys_clk), .rst(rst), .cpuIrqLine(cpuIrqLine), .autoAck(autoAck),
    .forceAck(forceAck), .gap(gap), .ackCycle(ackCycle));
  task check(input [31:0] seen, input [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("Counts: %0d checks, %0d failures", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task step(inout integer n);
    @(posedge sys_clk);
    n = n + 1;
    if (n > 200) begin
      failures = failures + 1;
      wrap_up;
    end
  endtask
  task wr(input [11:0] a, input [7:0] d, input [1:0] resp);
    integer n;
    reg awDone, wDone;
    n = 0;
    awDone = 1'b0;
    wDone = 1'b0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(awDone && wDone)) begin
      step(n);
      if (awready && !awDone) begin
        awvalid <= 1'b0;
        awDone = 1'b1;
      end
      if (wready && !wDone) begin
        wvalid <= 1'b0;
        wDone = 1'b1;
      end
    end
    do step(n); while (!bvalid);
    check(bresp, resp);
  endtask
  task rd(input [11:0] a, input [7:0] exp, input [1:0] resp);
    integer n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do step(n); while (!arready);
    arvalid <= 1'b0;
    do step(n); while (!rvalid);
    check(rdata, {24'h0, exp});
    check(rresp, resp);
  endtask
  task vec(input [7:0] exp, input want);
    integer n;
    reg got;
    n = 0;
    got = 1'b0;
    while (n < 40 && !got) begin
      @(posedge sys_clk);
      n = n + 1;
      got = vectorValid;
    end
    check(got, want);
    if (got) check(systemDataBus, exp);
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    check(cpuIrqLine, 1'b0);
    wr(12'h084, 8'hff, 2'h0);
    for (i = 0; i < 8; i = i + 1) wr(initTab[i][19:8], initTab[i][7:0], 2'h0);
    rd(12'h084, 8'h00, 2'h0);
    $display("init done");
    masterPins <= 5'h01;
    vec(8'h0b, 1'b1);
    masterPins <= 5'h05;
    vec(8'h00, 1'b0);
    extRequestPin1 <= 1'b1;
    vec(8'h09, 1'b1);
    wr(12'h080, 8'h0b, 2'h0);
    rd(12'h080, 8'h0a, 2'h0);
    wr(12'h080, 8'h20, 2'h0);
    rd(12'h080, 8'h08, 2'h0);
    wr(12'h080, 8'h63, 2'h0);
    vec(8'h0d, 1'b1);
    wr(12'h080, 8'h65, 2'h0);
    masterPins <= 5'h00;
    extRequestPin1 <= 1'b0;
    rd(12'h080, 8'h00, 2'h0);
    $display("nesting done");
    gap <= 4'h3;
    slavePins <= 7'h08;
    vec(8'h74, 1'b1);
    wr(12'h280, 8'h20, 2'h0);
    wr(12'h080, 8'h20, 2'h0);
    slavePins <= 7'h00;
    rtcIrq <= 1'b1;
    vec(8'h70, 1'b1);
    wr(12'h280, 8'h20, 2'h0);
    wr(12'h080, 8'h20, 2'h0);
    rtcIrq <= 1'b0;
    timerOut0 <= 1'b1;
    vec(8'h08, 1'b1);
    wr(12'h080, 8'h20, 2'h0);
    timerOut0 <= 1'b0;
    $display("cascade done");
    forceAck <= 1'b1;
    i = 0;
    do step(i); while (!ackCycle);
    forceAck <= 1'b0;
    vec(8'h0f, 1'b1);
    rd(12'h080, 8'h00, 2'h0);
    $display("spurious done");
    wr(12'h080, 8'hc5, 2'h0);
    masterPins <= 5'h09;
    vec(8'h0e, 1'b1);
    wr(12'h080, 8'h66, 2'h0);
    vec(8'h0b, 1'b1);
    wr(12'h080, 8'h63, 2'h0);
    masterPins <= 5'h00;
    $display("rotation done");
    wr(12'h080, 8'h11, 2'h0);
    for (i = 1; i < 3; i = i + 1) wr(initTab[i][19:8], initTab[i][7:0], 2'h0);
    wr(12'h084, 8'h03, 2'h0);
    wr(12'h080, 8'h80, 2'h0);
    wr(12'h080, 8'h0b, 2'h0);
    masterPins <= 5'h01;
    vec(8'h0b, 1'b1);
    rd(12'h080, 8'h00, 2'h0);
    wr(12'h084, 8'hff, 2'h0);
    masterPins <= 5'h03;
    extRequestPin1 <= 1'b1;
    wr(12'h084, 8'h00, 2'h0);
    vec(8'h0c, 1'b1);
    vec(8'h09, 1'b1);
    masterPins <= 5'h00;
    extRequestPin1 <= 1'b0;
    $display("auto end done");
    wr(12'h080, 8'h19, 2'h0);
    for (i = 1; i < 4; i = i + 1) wr(initTab[i][19:8], initTab[i][7:0], 2'h0);
    wr(12'h084, 8'hff, 2'h0);
    timerOut0 <= 1'b1;
    @(posedge sys_clk);
    rd(12'h080, 8'h01, 2'h0);
    timerOut0 <= 1'b0;
    @(posedge sys_clk);
    rd(12'h080, 8'h00, 2'h0);
    $display("level done");
    wr(12'h100, 8'h00, 2'h2);
    rd(12'h100, 8'h00, 2'h2);
    $display("bus errors done");
    wrap_up;
  end
endmodule // tb_cascaded_interrupt_controller
